// [acdb_pkg.sv]
// constants shared by the audio clock divider bank
// assumes a 32-bit classic Wishbone slave port, registers on byte address 4*index
// What this block does
// RULE1: dsp clock is source clock divided by seven-bit field plus one, 1 to 128.
// RULE2: converter clock is source clock divided by field plus one; zero divides by one.
// RULE3: pump clock is source clock divided by field plus one, range 1 to 128.
// RULE4: oversampling clock is source clock divided by field plus one, range 1 to 128.
// RULE5: in auto set mode the four source dividers use built-in ratios instead.
// RULE6: master bit clock is mclk divided by seven-bit field plus one, 1 to 128.
// RULE7: master frame clock is bit clock divided by eight-bit field plus one, 1 to 256.
// RULE8: interpolation bit clear selects 8x, set selects 16x.
// RULE9: software sets speed mode to the sample rate; ignored in auto set mode.
// RULE10: disable bit turns auto set off; software then programs every divider itself.
// RULE11: reserved top bit of each seven-bit divider register reads zero and ignores writes.
package acdb_pkg;
    localparam int REG_W = 8;
    localparam int DIV_W = 7;
    localparam int FRAME_W = 8;
    localparam int RATE_W = 3;
    localparam int WB_ADR_W = 10;
    localparam int WB_DAT_W = 32;
    localparam int IDX_W = 8;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_DSP_DIV = 8'h1B;
    localparam logic [IDX_W-1:0] IDX_CONVERTER_DIV = 8'h1C;
    localparam logic [IDX_W-1:0] IDX_PUMP_DIV = 8'h1D;
    localparam logic [IDX_W-1:0] IDX_OVERSAMPLE_DIV = 8'h1E;
    localparam logic [IDX_W-1:0] IDX_MASTER_BIT_DIV = 8'h20;
    localparam logic [IDX_W-1:0] IDX_MASTER_FRAME_DIV = 8'h21;
    localparam logic [IDX_W-1:0] IDX_INTERP_SPEED = 8'h22;
    localparam logic [IDX_W-1:0] IDX_MASTER_MODE = 8'h24;
    localparam logic [IDX_W-1:0] IDX_AUTOSET_CTRL = 8'h25;
    localparam logic [IDX_W-1:0] IDX_STATUS = 8'h26;

    // reset values of the stored fields
    localparam logic [DIV_W-1:0] RST_DSP_DIV = 7'h00;
    localparam logic [DIV_W-1:0] RST_CONVERTER_DIV = 7'h01;
    localparam logic [DIV_W-1:0] RST_PUMP_DIV = 7'h01;
    localparam logic [DIV_W-1:0] RST_OVERSAMPLE_DIV = 7'h01;
    localparam logic [DIV_W-1:0] RST_MASTER_BIT_DIV = 7'h00;
    localparam logic [FRAME_W-1:0] RST_MASTER_FRAME_DIV = 8'h00;
    localparam logic RST_INTERP_X16 = 1'b0;
    localparam logic [RATE_W-1:0] RST_RATE_SPEED = 3'h0;
    localparam logic RST_MASTER_MODE = 1'b0;
    localparam logic RST_AUTOSET_DISABLE = 1'b0;

    // field positions
    localparam int INTERP_X16_BIT = 4;
    localparam int RATE_SPEED_LSB = 0;
    localparam int MASTER_MODE_BIT = 0;
    localparam int AUTOSET_DISABLE_BIT = 1;

    // ratios used while auto set mode is active
    localparam logic [DIV_W-1:0] AUTO_DSP_DIV = 7'h01;
    localparam logic [DIV_W-1:0] AUTO_CONVERTER_DIV = 7'h0F;
    localparam logic [DIV_W-1:0] AUTO_PUMP_DIV = 7'h03;
    localparam logic [DIV_W-1:0] AUTO_OVERSAMPLE_DIV = 7'h0F;
    localparam logic [RATE_W-1:0] AUTO_RATE_SPEED = 3'h0;
endpackage

// [acdb_edge_sync.sv]
// two-flop synchroniser with rising edge detect for a clock arriving on a pin
// assumes the pin toggles slower than half the system clock rate
module acdb_edge_sync (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic rawIn,
    output logic levelOut,
    output logic riseOut
);
    logic firstStage;
    logic secondStage;
    logic thirdStage;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            firstStage <= 1'b0;
            secondStage <= 1'b0;
            thirdStage <= 1'b0;
        end else begin
            firstStage <= rawIn;
            secondStage <= firstStage;
            thirdStage <= secondStage;
        end
    end

    assign levelOut = secondStage;
    assign riseOut = secondStage & ~thirdStage;
endmodule // acdb_edge_sync

// [acdb_clk_div.sv]
// divide-by-(value+1) counter stepped by rising edges of a sampled clock
// assumes edgeTick is a one-cycle pulse per input rising edge, levelIn its level
module acdb_clk_div #(
    parameter int W = 7
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic restart,
    input wire logic edgeTick,
    input wire logic levelIn,
    input wire logic [W-1:0] divValue,
    output logic clkOut,
    output logic tickOut
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic bypass;

    assign bypass = (divValue == '0);

    always_comb begin
        if (cnt_reg >= divValue) begin
            cnt_next = '0;
        end else begin
            cnt_next = W'(cnt_reg + 1'b1);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || !enable || restart) begin
            // all ones: the first input edge wraps to zero and opens a full period
            cnt_reg <= '1;
        end else if (edgeTick) begin
            cnt_reg <= cnt_next;
        end
    end

    // high for the first half of each period, low for the rest
    always_ff @(posedge clock) begin
        if (sys_rst || !enable || restart) begin
            clkOut <= 1'b0;
        end else if (bypass) begin
            clkOut <= levelIn;
        end else if (edgeTick) begin
            clkOut <= (cnt_next <= (divValue >> 1));
        end
    end

    // marks each rising edge of clkOut
    always_ff @(posedge clock) begin
        if (sys_rst || !enable || restart) begin
            tickOut <= 1'b0;
        end else begin
            tickOut <= edgeTick && (bypass || (cnt_next == '0));
        end
    end
endmodule // acdb_clk_div

// [acdb_top.sv]
// audio clock divider bank with a classic Wishbone register slave
// assumes source clock and mclk arrive on pins, each below half the system clock
module acdb_top #(
    parameter logic [acdb_pkg::DIV_W-1:0] AUTO_DSP = acdb_pkg::AUTO_DSP_DIV,
    parameter logic [acdb_pkg::DIV_W-1:0] AUTO_CONVERTER = acdb_pkg::AUTO_CONVERTER_DIV,
    parameter logic [acdb_pkg::DIV_W-1:0] AUTO_PUMP = acdb_pkg::AUTO_PUMP_DIV,
    parameter logic [acdb_pkg::DIV_W-1:0] AUTO_OVERSAMPLE = acdb_pkg::AUTO_OVERSAMPLE_DIV,
    parameter logic [acdb_pkg::RATE_W-1:0] AUTO_RATE = acdb_pkg::AUTO_RATE_SPEED
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [acdb_pkg::WB_ADR_W-1:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [acdb_pkg::WB_DAT_W-1:0] wbDatIn,
    output logic [acdb_pkg::WB_DAT_W-1:0] wbDatOut,
    output logic wbAck,
    input wire logic sourceClkIn,
    input wire logic mclkIn,
    output logic dspClk,
    output logic converterClk,
    output logic pumpClk,
    output logic oversampleClk,
    output logic masterBitClk,
    output logic masterFrameClk,
    output logic interpX16Select,
    output logic [acdb_pkg::RATE_W-1:0] rateSpeedSelect,
    output logic autosetActive
);
    logic [acdb_pkg::DIV_W-1:0] dspDivValue_reg;
    logic [acdb_pkg::DIV_W-1:0] converterDivValue_reg;
    logic [acdb_pkg::DIV_W-1:0] pumpDivValue_reg;
    logic [acdb_pkg::DIV_W-1:0] oversampleDivValue_reg;
    logic [acdb_pkg::DIV_W-1:0] masterBitclkDivValue_reg;
    logic [acdb_pkg::FRAME_W-1:0] masterFrameclkDivValue_reg;
    logic interpX16Select_reg;
    logic [acdb_pkg::RATE_W-1:0] rateSpeedSelect_reg;
    logic masterMode_reg;
    logic autosetDisable_reg;

    logic [acdb_pkg::IDX_W-1:0] regIndex;
    logic busReq;
    logic wrEn;
    logic [acdb_pkg::REG_W-1:0] wrByte;
    logic [acdb_pkg::REG_W-1:0] rdByte;

    logic wrDsp;
    logic wrConverter;
    logic wrPump;
    logic wrOversample;
    logic wrMasterBit;
    logic wrMasterFrame;
    logic wrInterp;
    logic wrMasterMode;
    logic wrAutoset;

    logic autoMode;
    logic [acdb_pkg::DIV_W-1:0] dspDivEff;
    logic [acdb_pkg::DIV_W-1:0] converterDivEff;
    logic [acdb_pkg::DIV_W-1:0] pumpDivEff;
    logic [acdb_pkg::DIV_W-1:0] oversampleDivEff;
    logic [acdb_pkg::RATE_W-1:0] rateSpeedEff;

    logic srcLevel;
    logic srcRise;
    logic mclkLevel;
    logic mclkRise;
    logic bitTick;
    logic srcRestart;

    // ---------------- bus slave ----------------
    // one request per access; ack rises one cycle after the request is seen
    assign regIndex = wbAdr[acdb_pkg::WB_ADR_W-1:2];
    assign busReq = wbCyc && wbStb && !wbAck;
    assign wrEn = busReq && wbWe && wbSel[0];
    assign wrByte = wbDatIn[acdb_pkg::REG_W-1:0];

    assign wrDsp = wrEn && (regIndex == acdb_pkg::IDX_DSP_DIV);
    assign wrConverter = wrEn && (regIndex == acdb_pkg::IDX_CONVERTER_DIV);
    assign wrPump = wrEn && (regIndex == acdb_pkg::IDX_PUMP_DIV);
    assign wrOversample = wrEn && (regIndex == acdb_pkg::IDX_OVERSAMPLE_DIV);
    assign wrMasterBit = wrEn && (regIndex == acdb_pkg::IDX_MASTER_BIT_DIV);
    assign wrMasterFrame = wrEn && (regIndex == acdb_pkg::IDX_MASTER_FRAME_DIV);
    assign wrInterp = wrEn && (regIndex == acdb_pkg::IDX_INTERP_SPEED);
    assign wrMasterMode = wrEn && (regIndex == acdb_pkg::IDX_MASTER_MODE);
    assign wrAutoset = wrEn && (regIndex == acdb_pkg::IDX_AUTOSET_CTRL);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wbAck <= 1'b0;
        end else begin
            wbAck <= busReq;
        end
    end

    // unmapped indices read zero and writes to them are dropped
    always_comb begin
        rdByte = 8'h00;
        case (regIndex)
            acdb_pkg::IDX_DSP_DIV: begin
                rdByte = {1'b0, dspDivValue_reg}; // [RULE11]
            end
            acdb_pkg::IDX_CONVERTER_DIV: begin
                rdByte = {1'b0, converterDivValue_reg}; // [RULE11]
            end
            acdb_pkg::IDX_PUMP_DIV: begin
                rdByte = {1'b0, pumpDivValue_reg}; // [RULE11]
            end
            acdb_pkg::IDX_OVERSAMPLE_DIV: begin
                rdByte = {1'b0, oversampleDivValue_reg}; // [RULE11]
            end
            acdb_pkg::IDX_MASTER_BIT_DIV: begin
                rdByte = {1'b0, masterBitclkDivValue_reg}; // [RULE11]
            end
            acdb_pkg::IDX_MASTER_FRAME_DIV: begin
                rdByte = masterFrameclkDivValue_reg;
            end
            acdb_pkg::IDX_INTERP_SPEED: begin
                rdByte[acdb_pkg::INTERP_X16_BIT] = interpX16Select_reg;
                rdByte[acdb_pkg::RATE_SPEED_LSB +: acdb_pkg::RATE_W] = rateSpeedSelect_reg;
            end
            acdb_pkg::IDX_MASTER_MODE: begin
                rdByte[acdb_pkg::MASTER_MODE_BIT] = masterMode_reg;
            end
            acdb_pkg::IDX_AUTOSET_CTRL: begin
                rdByte[acdb_pkg::AUTOSET_DISABLE_BIT] = autosetDisable_reg;
            end
            acdb_pkg::IDX_STATUS: begin
                rdByte = {masterFrameClk, masterBitClk, oversampleClk, pumpClk,
                          converterClk, dspClk, masterMode_reg, autoMode};
            end
            default: begin
                rdByte = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wbDatOut <= 32'h0000_0000;
        end else if (busReq && !wbWe) begin
            wbDatOut <= {24'h00_0000, rdByte};
        end
    end

    // ---------------- registers ----------------
    // bit 7 of each seven-bit divider is never stored
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            dspDivValue_reg <= acdb_pkg::RST_DSP_DIV;
        end else if (wrDsp) begin
            dspDivValue_reg <= wrByte[acdb_pkg::DIV_W-1:0]; // [RULE11]
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            converterDivValue_reg <= acdb_pkg::RST_CONVERTER_DIV;
        end else if (wrConverter) begin
            converterDivValue_reg <= wrByte[acdb_pkg::DIV_W-1:0]; // [RULE11]
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pumpDivValue_reg <= acdb_pkg::RST_PUMP_DIV;
        end else if (wrPump) begin
            pumpDivValue_reg <= wrByte[acdb_pkg::DIV_W-1:0]; // [RULE11]
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            oversampleDivValue_reg <= acdb_pkg::RST_OVERSAMPLE_DIV;
        end else if (wrOversample) begin
            oversampleDivValue_reg <= wrByte[acdb_pkg::DIV_W-1:0]; // [RULE11]
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            masterBitclkDivValue_reg <= acdb_pkg::RST_MASTER_BIT_DIV;
        end else if (wrMasterBit) begin
            masterBitclkDivValue_reg <= wrByte[acdb_pkg::DIV_W-1:0]; // [RULE11]
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            masterFrameclkDivValue_reg <= acdb_pkg::RST_MASTER_FRAME_DIV;
        end else if (wrMasterFrame) begin
            masterFrameclkDivValue_reg <= wrByte;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            interpX16Select_reg <= acdb_pkg::RST_INTERP_X16;
            rateSpeedSelect_reg <= acdb_pkg::RST_RATE_SPEED;
        end else if (wrInterp) begin
            interpX16Select_reg <= wrByte[acdb_pkg::INTERP_X16_BIT];
            rateSpeedSelect_reg <= wrByte[acdb_pkg::RATE_SPEED_LSB +: acdb_pkg::RATE_W];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            masterMode_reg <= acdb_pkg::RST_MASTER_MODE;
        end else if (wrMasterMode) begin
            masterMode_reg <= wrByte[acdb_pkg::MASTER_MODE_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            autosetDisable_reg <= acdb_pkg::RST_AUTOSET_DISABLE;
        end else if (wrAutoset) begin
            autosetDisable_reg <= wrByte[acdb_pkg::AUTOSET_DISABLE_BIT]; // [RULE10]
        end
    end

    // ---------------- effective ratios ----------------
    assign autoMode = !autosetDisable_reg; // [RULE10]
    assign dspDivEff = autoMode ? AUTO_DSP : dspDivValue_reg; // [RULE5]
    assign converterDivEff = autoMode ? AUTO_CONVERTER : converterDivValue_reg; // [RULE5]
    assign pumpDivEff = autoMode ? AUTO_PUMP : pumpDivValue_reg; // [RULE5]
    assign oversampleDivEff = autoMode ? AUTO_OVERSAMPLE : oversampleDivValue_reg; // [RULE5]
    assign rateSpeedEff = autoMode ? AUTO_RATE : rateSpeedSelect_reg; // [RULE9]

    // a mode change realigns all source dividers at once
    assign srcRestart = wrAutoset;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            interpX16Select <= acdb_pkg::RST_INTERP_X16;
            rateSpeedSelect <= acdb_pkg::RST_RATE_SPEED;
            autosetActive <= 1'b1;
        end else begin
            interpX16Select <= interpX16Select_reg; // [RULE8]
            rateSpeedSelect <= rateSpeedEff; // [RULE9]
            autosetActive <= autoMode;
        end
    end

    // ---------------- clock inputs ----------------
    acdb_edge_sync u_src_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .rawIn(sourceClkIn),
        .levelOut(srcLevel),
        .riseOut(srcRise)
    );

    acdb_edge_sync u_mclk_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .rawIn(mclkIn),
        .levelOut(mclkLevel),
        .riseOut(mclkRise)
    );

    // ---------------- source clock dividers ----------------
    // rewriting a divider restarts it so the new ratio starts on a clean period
    acdb_clk_div #(.W(acdb_pkg::DIV_W)) u_dsp_div (
        .clock(clock),
        .sys_rst(sys_rst),
        .enable(1'b1),
        .restart(srcRestart || wrDsp),
        .edgeTick(srcRise),
        .levelIn(srcLevel),
        .divValue(dspDivEff), // [RULE1]
        .clkOut(dspClk),
        .tickOut()
    );

    acdb_clk_div #(.W(acdb_pkg::DIV_W)) u_converter_div (
        .clock(clock),
        .sys_rst(sys_rst),
        .enable(1'b1),
        .restart(srcRestart || wrConverter),
        .edgeTick(srcRise),
        .levelIn(srcLevel),
        .divValue(converterDivEff), // [RULE2]
        .clkOut(converterClk),
        .tickOut()
    );

    acdb_clk_div #(.W(acdb_pkg::DIV_W)) u_pump_div (
        .clock(clock),
        .sys_rst(sys_rst),
        .enable(1'b1),
        .restart(srcRestart || wrPump),
        .edgeTick(srcRise),
        .levelIn(srcLevel),
        .divValue(pumpDivEff), // [RULE3]
        .clkOut(pumpClk),
        .tickOut()
    );

    acdb_clk_div #(.W(acdb_pkg::DIV_W)) u_oversample_div (
        .clock(clock),
        .sys_rst(sys_rst),
        .enable(1'b1),
        .restart(srcRestart || wrOversample),
        .edgeTick(srcRise),
        .levelIn(srcLevel),
        .divValue(oversampleDivEff), // [RULE4]
        .clkOut(oversampleClk),
        .tickOut()
    );

    // ---------------- master bit and frame clocks ----------------
    // both held low outside master mode; frame follows bit clock edges
    acdb_clk_div #(.W(acdb_pkg::DIV_W)) u_bit_div (
        .clock(clock),
        .sys_rst(sys_rst),
        .enable(masterMode_reg),
        .restart(wrMasterBit),
        .edgeTick(mclkRise),
        .levelIn(mclkLevel),
        .divValue(masterBitclkDivValue_reg), // [RULE6]
        .clkOut(masterBitClk),
        .tickOut(bitTick)
    );

    acdb_clk_div #(.W(acdb_pkg::FRAME_W)) u_frame_div (
        .clock(clock),
        .sys_rst(sys_rst),
        .enable(masterMode_reg),
        .restart(wrMasterBit || wrMasterFrame),
        .edgeTick(bitTick),
        .levelIn(masterBitClk),
        .divValue(masterFrameclkDivValue_reg), // [RULE7]
        .clkOut(masterFrameClk),
        .tickOut()
    );
endmodule // acdb_top

// [acdb_checker.sv]
// assertions on the ports of the audio clock divider bank
// assumes clock pins hold each level for at least three system cycles
module acdb_checker #(
    parameter logic [acdb_pkg::RATE_W-1:0] AUTO_RATE = acdb_pkg::AUTO_RATE_SPEED
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [acdb_pkg::WB_ADR_W-1:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [acdb_pkg::WB_DAT_W-1:0] wbDatIn,
    input wire logic [acdb_pkg::WB_DAT_W-1:0] wbDatOut,
    input wire logic wbAck,
    input wire logic sourceClkIn,
    input wire logic mclkIn,
    input wire logic dspClk,
    input wire logic converterClk,
    input wire logic masterBitClk,
    input wire logic masterFrameClk,
    input wire logic interpX16Select,
    input wire logic [acdb_pkg::RATE_W-1:0] rateSpeedSelect,
    input wire logic autosetActive
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    wire logic [7:0] idx = wbAdr[9:2];
    logic bitPrev;
    logic [2:0] sinceBit;
    // cycles since the master bit clock last rose, saturating
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bitPrev <= 1'b0;
            sinceBit <= 3'h7;
        end else begin
            bitPrev <= masterBitClk;
            if (masterBitClk && !bitPrev) begin
                sinceBit <= 3'h0;
            end else if (sinceBit != 3'h7) begin
                sinceBit <= sinceBit + 3'h1;
            end
        end
    end
    sequence s_take;
        wbCyc && wbStb && !wbAck;
    endsequence
    sequence s_write(logic [7:0] i);
        wbCyc && wbStb && !wbAck && wbWe && wbSel[0] && idx == i;
    endsequence
    property p_ack_one;
        s_take |=> wbAck;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("request not acked next cycle");
    property p_ack_drop;
        wbAck |=> !wbAck;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("ack longer than one cycle");
    property p_reserved;
        wbAck && !wbWe && idx inside {8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h20}
            |-> wbDatOut[31:7] == 25'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("divider top bit read as one");
    property p_interp;
        s_write(8'h22) |=> ##1 interpX16Select == $past(wbDatIn[4], 2);
    endproperty
    a_interp: assert property (p_interp) else $error("interpolation select wrong");
    property p_rate;
        autosetActive && $past(autosetActive) |-> rateSpeedSelect == AUTO_RATE;
    endproperty
    a_rate: assert property (p_rate) else $error("speed select not fixed in auto mode");
    property p_autoset;
        s_write(8'h25) |=> ##1 autosetActive == !$past(wbDatIn[1], 2);
    endproperty
    a_autoset: assert property (p_autoset) else $error("auto set state wrong");
    property p_dsp;
        $rose(dspClk) |-> $past(sourceClkIn, 3) || $past(sourceClkIn, 4);
    endproperty
    a_dsp: assert property (p_dsp) else $error("dsp clock rose off a source edge");
    property p_conv;
        $rose(converterClk) |-> $past(sourceClkIn, 3) || $past(sourceClkIn, 4);
    endproperty
    a_conv: assert property (p_conv) else $error("converter clock rose off an edge");
    property p_bit;
        $rose(masterBitClk) |-> $past(mclkIn, 3) || $past(mclkIn, 4);
    endproperty
    a_bit: assert property (p_bit) else $error("bit clock rose off an mclk edge");
    property p_frame;
        $rose(masterFrameClk) |-> (masterBitClk && !bitPrev) || sinceBit < 3'h6;
    endproperty
    a_frame: assert property (p_frame) else $error("frame clock rose off a bit edge");
endmodule // acdb_checker

bind acdb_top acdb_checker #(.AUTO_RATE(AUTO_RATE)) u_chk (.clock(clock), .sys_rst(sys_rst),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck), .sourceClkIn(sourceClkIn),
    .mclkIn(mclkIn), .dspClk(dspClk), .converterClk(converterClk),
    .masterBitClk(masterBitClk), .masterFrameClk(masterFrameClk),
    .interpX16Select(interpX16Select), .rateSpeedSelect(rateSpeedSelect),
    .autosetActive(autosetActive));

// [acdb_mclk_host.sv]
// far-side audio host model: supplies a free-running mclk
// assumes the system clock paces it; slow stretches each level from 3 to 5 cycles
module acdb_mclk_host (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic slow,
    output logic mclk
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] phase;
    always @(posedge clock) begin
        if (sys_rst) begin
            phase <= 3'h0;
            mclk <= 1'b0;
        end else if (phase >= (slow ? 3'h4 : 3'h2)) begin
            phase <= 3'h0;
            mclk <= !mclk;
        end else begin
            phase <= phase + 3'h1;
        end
    end
endmodule // acdb_mclk_host

// [acdb_top_tb.sv]
// self-checking bench for the audio clock divider bank
// assumes 50 MHz system clock; source clock made here, mclk by the host model
module acdb_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, sourceClkIn = 1'b0, slow = 1'b0;
    logic [9:0] wbAdr = 10'h0;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatIn = 32'h0;
    logic [31:0] wbDatOut;
    logic wbAck, mclkIn, interpX16Select, autosetActive;
    wire [5:0] outs;
    logic [2:0] rateSpeedSelect, measSel = 3'h0;
    logic [1:0] measState = 2'h0, srcPhase = 2'h0;
    logic prevIn = 1'b0, prevOut = 1'b0;
    logic [7:0] rdQ[$];
    int ratioQ[$];
    int n_fail = 0, checked = 0, measCnt = 0, v;
    wire logic [5:0] ins = {outs[4], mclkIn, {4{sourceClkIn}}};
    always #10 clock = !clock;
    acdb_top u_dut (.clock(clock), .sys_rst(sys_rst), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut),
        .wbAck(wbAck), .sourceClkIn(sourceClkIn), .mclkIn(mclkIn), .dspClk(outs[0]),
        .converterClk(outs[1]), .pumpClk(outs[2]), .oversampleClk(outs[3]),
        .masterBitClk(outs[4]), .masterFrameClk(outs[5]), .interpX16Select(interpX16Select),
        .rateSpeedSelect(rateSpeedSelect), .autosetActive(autosetActive));
    acdb_mclk_host u_host (.clock(clock), .sys_rst(sys_rst), .slow(slow), .mclk(mclkIn));
    task automatic compare_data(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t data %h expected %h", $time, got, exp);
        end
    endtask
    task automatic compare_ratio(input int got, input int exp);
        checked++;
        if (got != exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t ratio %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // one classic cycle; random filler in the unused data bits
    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        r = $urandom();
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= {idx, 2'h0};
        wbSel <= 4'hF;
        wbDatIn <= {r[23:0], d};
        @(posedge clock);
        while (!wbAck) @(posedge clock);
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        rdQ.push_back(exp);
        wb(1'b0, idx, 8'h00);
    endtask
    // input rising edges per output period of clock s
    task automatic measure(input logic [2:0] s, input int n);
        ratioQ.push_back(n);
        measSel <= s;
        repeat (2) @(posedge clock);
        measState <= 2'h1;
        @(posedge clock);
        while (measState != 2'h0) @(posedge clock);
    endtask
    always @(posedge clock) begin
        srcPhase <= (srcPhase == 2'h2) ? 2'h0 : srcPhase + 2'h1;
        if (srcPhase == 2'h2) begin
            sourceClkIn <= !sourceClkIn;
        end
    end
    // watcher: read data on ack, divide ratios between output rises
    always @(posedge clock) begin
        if (wbCyc && wbStb && wbAck && !wbWe) begin
            compare_data(wbDatOut, {24'h0, rdQ.pop_front()});
        end
        if (ins[measSel] && !prevIn && measState == 2'h2) begin
            measCnt++;
        end
        if (outs[measSel] && !prevOut && measState != 2'h0) begin
            if (measState == 2'h2) begin
                compare_ratio(measCnt, ratioQ.pop_front());
            end
            measState <= (measState == 2'h2) ? 2'h0 : 2'h2;
            measCnt = 0;
        end
        prevIn <= ins[measSel];
        prevOut <= outs[measSel];
    end
    initial begin
        #(20 * 60000);
        n_fail++;
        print_verdict();
    end
    initial begin
        logic [7:0] idxs[7] = '{8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h20, 8'h21, 8'h22};
        logic [7:0] rstv[7] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
        logic [7:0] full[7] = '{8'h7F, 8'h7F, 8'h7F, 8'h7F, 8'h7F, 8'hFF, 8'h17};
        int autoR[4] = '{acdb_pkg::AUTO_DSP_DIV, acdb_pkg::AUTO_CONVERTER_DIV,
            acdb_pkg::AUTO_PUMP_DIV, acdb_pkg::AUTO_OVERSAMPLE_DIV};
        int vals[3];
        void'($urandom(25438));
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clock);
        for (int i = 0; i < 7; i++) rd(idxs[i], rstv[i]);
        for (int i = 0; i < 7; i++) wb(1'b1, idxs[i], 8'hFF);
        for (int i = 0; i < 7; i++) rd(idxs[i], full[i]);
        wb(1'b1, 8'h30, 8'hFF);
        rd(8'h30, 8'h00);
        compare_data({interpX16Select, rateSpeedSelect}, 4'h8);
        for (int i = 0; i < 4; i++) measure(i[2:0], autoR[i] + 1);
        wb(1'b1, 8'h25, 8'h02);
        compare_data({autosetActive, rateSpeedSelect}, 4'h7);
        vals = '{0, 127, $urandom_range(126, 1)};
        for (int i = 0; i < 4; i++) begin
            foreach (vals[j]) begin
                wb(1'b1, idxs[i], vals[j][7:0]);
                measure(i[2:0], vals[j] + 1);
            end
        end
        wb(1'b1, 8'h24, 8'h01);
        measure(3'h4, 128);
        v = $urandom_range(20, 1);
        slow <= 1'b1;
        wb(1'b1, 8'h20, v[7:0]);
        measure(3'h4, v + 1);
        slow <= 1'b0;
        wb(1'b1, 8'h20, 8'h00);
        measure(3'h5, 256);
        v = $urandom_range(60, 0);
        wb(1'b1, 8'h21, v[7:0]);
        measure(3'h5, v + 1);
        wb(1'b1, 8'h22, 8'h00);
        compare_data({interpX16Select, rateSpeedSelect}, 4'h0);
        print_verdict();
    end
endmodule // acdb_top_tb
